//--- rtl/fcc_cycle_clock.v
// Fieldbus system cycle clock derivation: bus, servo, interpolator cycles
// How it works
// - All cycles derive from internal bus cycle
// - Bus cycle at least 0.5 ms, 0.125 grid
// - External port cycle must be 1 ms+
// - Internal bus isochronous, shown as data cycle
// - Servo, interpolator, second interpolator ratio ranges
// - Servo reduction ratio only without IRT
// - Masters only: use internal module clock
// - At most one isochronous slave port
// - Slave port cycle drives system cycles
// - No slave sync: use substitute clock
// - External port cycle integer multiple allowed
// - Scaling only on an isochronous slave port
// - Other port iso master at equal cycle
// - Free-running ports do not affect cycles
// - Axes may use different interpolator levels
// - Ignore new address without fieldbus network
`include "fcc_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module fcc_cycle_clock #(
	parameter STEP_W = 8,
	parameter GRID_CYC = `FCC_GRID_CYC
) (
	// Clock and reset
	input wire sys_clk,
	input wire rst,
	// Configuration load
	input wire cfg_load,
	input wire [STEP_W-1:0] cfg_bus_steps,
	input wire [3:0] cfg_servo_ratio,
	input wire [3:0] cfg_ipo_ratio,
	input wire [6:0] cfg_second_interpolator_cycle_ratio,
	input wire cfg_irt,
	input wire [1:0] cfg_port1_mode,
	input wire [1:0] cfg_port2_mode,
	input wire [STEP_W-1:0] cfg_port1_steps,
	input wire [STEP_W-1:0] cfg_port2_steps,
	input wire cfg_port1_net,
	input wire cfg_port2_net,
	input wire [6:0] cfg_bus_addr,
	// Slave port cycle input
	input wire port1_slave_cycle,
	input wire port2_slave_cycle,
	input wire port1_sync_ok,
	input wire port2_sync_ok,
	// Cycle outputs
	output reg bus_data_cycle,
	output reg servo_cycle,
	output reg interpolator_cycle,
	output reg second_interpolator_cycle,
	output reg first_external_fieldbus_port_cycle,
	output reg second_external_fieldbus_port_cycle,
	// Status
	output reg cfg_valid,
	output reg [`FCC_ERR_W-1:0] cfg_error,
	output reg using_slave_clock,
	output reg using_substitute_clock,
	output reg [6:0] bus_addr
);
	localparam ST_INT = 3'b001;
	localparam ST_SLAVE = 3'b010;
	localparam ST_SUBST = 3'b100;
	localparam [15:0] GRID = GRID_CYC;

	// Port is configured as an isochronous slave
	function is_slave;
		input [1:0] mode;
		begin
			is_slave = (mode == `FCC_MODE_ISO_SLAVE);
		end
	endfunction

	function is_iso;
		input [1:0] mode;
		begin
			is_iso = (mode == `FCC_MODE_ISO_MASTER) || (mode == `FCC_MODE_ISO_SLAVE);
		end
	endfunction

	// Active configuration
	reg [STEP_W-1:0] bus_steps;
	reg [3:0] servo_ratio;
	reg [3:0] ipo_ratio;
	reg [6:0] second_interpolator_cycle_ratio;
	reg [1:0] p1_mode;
	reg [1:0] p2_mode;
	reg [STEP_W-1:0] p1_scale;
	reg [STEP_W-1:0] p2_scale;
	reg [2:0] state;
	reg [2:0] next_state;
	reg [`FCC_ERR_W-1:0] next_err;
	reg restart;

	// Configuration checking
	always @* begin
		next_err = {`FCC_ERR_W{1'b0}};
		if (cfg_bus_steps < `FCC_BUS_MIN_STEPS)
			next_err[`FCC_ERR_BUS] = 1'b1;
		if ((is_iso(cfg_port1_mode) && cfg_port1_steps < `FCC_EXT_MIN_STEPS) ||
		    (is_iso(cfg_port2_mode) && cfg_port2_steps < `FCC_EXT_MIN_STEPS))
			next_err[`FCC_ERR_EXT] = 1'b1;
		if (cfg_servo_ratio == 4'h0 || cfg_servo_ratio > `FCC_SERVO_MAX)
			next_err[`FCC_ERR_SERVO] = 1'b1;
		if (cfg_ipo_ratio == 4'h0 || cfg_ipo_ratio > `FCC_IPO_MAX ||
		    ({8'h00, cfg_bus_steps} * cfg_servo_ratio * cfg_ipo_ratio) < `FCC_IPO_MIN_STEPS)
			next_err[`FCC_ERR_IPO] = 1'b1;
		if (cfg_second_interpolator_cycle_ratio < `FCC_SECOND_INTERPOLATOR_CYCLE_MIN || cfg_second_interpolator_cycle_ratio > `FCC_SECOND_INTERPOLATOR_CYCLE_MAX)
			next_err[`FCC_ERR_SECOND_INTERPOLATOR_CYCLE] = 1'b1;
		if (cfg_irt && cfg_servo_ratio != 4'h1)
			next_err[`FCC_ERR_IRT] = 1'b1;
		if (is_slave(cfg_port1_mode) && is_slave(cfg_port2_mode))
			next_err[`FCC_ERR_TWO_SLAVES] = 1'b1;
		// Scaling is a multiple other than one on an iso master port while the other port is not a slave
		if ((cfg_port1_mode == `FCC_MODE_ISO_MASTER && cfg_port1_steps != cfg_bus_steps &&
		     !is_slave(cfg_port2_mode)) ||
		    (cfg_port2_mode == `FCC_MODE_ISO_MASTER && cfg_port2_steps != cfg_bus_steps &&
		     !is_slave(cfg_port1_mode)))
			next_err[`FCC_ERR_SCALE] = 1'b1;
		if ((is_slave(cfg_port1_mode) && cfg_port1_steps % cfg_bus_steps != {STEP_W{1'b0}}) ||
		    (is_slave(cfg_port2_mode) && cfg_port2_steps % cfg_bus_steps != {STEP_W{1'b0}}))
			next_err[`FCC_ERR_SCALE] = 1'b1;
		if ((is_slave(cfg_port1_mode) && cfg_port2_mode == `FCC_MODE_ISO_MASTER &&
		     cfg_port2_steps != cfg_bus_steps) ||
		    (is_slave(cfg_port2_mode) && cfg_port1_mode == `FCC_MODE_ISO_MASTER &&
		     cfg_port1_steps != cfg_bus_steps))
			next_err[`FCC_ERR_MASTER_CYC] = 1'b1;
	end

	// Load of configuration
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			bus_steps <= 8'h08;
			servo_ratio <= 4'h1;
			ipo_ratio <= 4'h1;
			second_interpolator_cycle_ratio <= 7'h02;
			p1_mode <= `FCC_MODE_OFF;
			p2_mode <= `FCC_MODE_OFF;
			p1_scale <= 8'h01;
			p2_scale <= 8'h01;
			cfg_valid <= 1'b1;
			cfg_error <= {`FCC_ERR_W{1'b0}};
			bus_addr <= `FCC_ADDR_DEFAULT;
			restart <= 1'b0;
		end else begin
			restart <= 1'b0;
			if (cfg_load) begin
				cfg_error <= next_err;
				cfg_valid <= (next_err == {`FCC_ERR_W{1'b0}});
				if (cfg_port1_net || cfg_port2_net)
					bus_addr <= cfg_bus_addr;
				if (next_err == {`FCC_ERR_W{1'b0}}) begin
					restart <= 1'b1;
					bus_steps <= cfg_bus_steps;
					servo_ratio <= cfg_servo_ratio;
					ipo_ratio <= cfg_ipo_ratio;
					second_interpolator_cycle_ratio <= cfg_second_interpolator_cycle_ratio;
					// Free-running ports leave the cycle settings alone
					p1_mode <= cfg_port1_mode;
					p2_mode <= cfg_port2_mode;
					p1_scale <= is_iso(cfg_port1_mode) ? cfg_port1_steps / cfg_bus_steps : 8'h01;
					p2_scale <= is_iso(cfg_port2_mode) ? cfg_port2_steps / cfg_bus_steps : 8'h01;
				end
			end
		end
	end

	// Clock source selection
	wire slave_present = is_slave(p1_mode) | is_slave(p2_mode);
	wire slave_sync = is_slave(p1_mode) ? port1_sync_ok : port2_sync_ok;
	wire slave_edge = is_slave(p1_mode) ? port1_slave_cycle : port2_slave_cycle;
	always @* begin
		case (state)
			ST_INT: next_state = slave_present ? (slave_sync ? ST_SLAVE : ST_SUBST) : ST_INT;
			ST_SLAVE: next_state = !slave_present ? ST_INT : (slave_sync ? ST_SLAVE : ST_SUBST);
			ST_SUBST: next_state = !slave_present ? ST_INT : (slave_sync ? ST_SLAVE : ST_SUBST);
			default: next_state = ST_INT;
		endcase
	end

	// Internal grid timer and bus cycle counter
	reg [15:0] grid_cnt;
	reg [STEP_W-1:0] step_cnt;
	reg int_bus;
	reg [STEP_W-1:0] slv_cnt;
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state <= ST_INT;
			grid_cnt <= 16'h0000;
			step_cnt <= {STEP_W{1'b0}};
			int_bus <= 1'b0;
			slv_cnt <= {STEP_W{1'b0}};
		end else begin
			state <= next_state;
			int_bus <= 1'b0;
			if (restart) begin
				grid_cnt <= 16'h0000;
				step_cnt <= {STEP_W{1'b0}};
			end else if (grid_cnt == GRID - 16'h0001) begin
				grid_cnt <= 16'h0000;
				if (step_cnt == bus_steps - {{(STEP_W-1){1'b0}}, 1'b1}) begin
					step_cnt <= {STEP_W{1'b0}};
					int_bus <= 1'b1;
				end else
					step_cnt <= step_cnt + {{(STEP_W-1){1'b0}}, 1'b1};
			end else
				grid_cnt <= grid_cnt + 16'h0001;
			// Slave port pulses arrive once per scaled cycle
			if (state == ST_SLAVE && slave_edge)
				slv_cnt <= {STEP_W{1'b0}};
			else if (int_bus && slv_cnt != {STEP_W{1'b1}})
				slv_cnt <= slv_cnt + {{(STEP_W-1){1'b0}}, 1'b1};
		end
	end

	// In slave mode the bus cycle is paced by the received cycle
	wire [STEP_W-1:0] slave_scale = is_slave(p1_mode) ? p1_scale : p2_scale;
	wire bus_tick = (state == ST_SLAVE) ? (slave_edge | (int_bus && slv_cnt < slave_scale - 8'h01 &&
	                slave_scale != 8'h01)) : int_bus;
	wire servo_tick;
	wire ipo_tick;
	wire second_interpolator_cycle_tick;
	wire p1_tick;
	wire p2_tick;

	// Servo from bus, interpolator from servo, second from interpolator
	fcc_divider #(.W(4)) u_servo (.sys_clk(sys_clk), .rst(rst), .restart(restart),
		.ratio(servo_ratio), .tick_in(bus_tick), .tick_out(servo_tick));
	fcc_divider #(.W(4)) u_ipo (.sys_clk(sys_clk), .rst(rst), .restart(restart),
		.ratio(ipo_ratio), .tick_in(servo_tick), .tick_out(ipo_tick));
	fcc_divider #(.W(7)) u_second_interpolator_cycle (.sys_clk(sys_clk), .rst(rst), .restart(restart),
		.ratio(second_interpolator_cycle_ratio), .tick_in(ipo_tick), .tick_out(second_interpolator_cycle_tick));
	fcc_divider #(.W(STEP_W)) u_p1 (.sys_clk(sys_clk), .rst(rst), .restart(restart),
		.ratio(p1_scale), .tick_in(bus_tick), .tick_out(p1_tick));
	fcc_divider #(.W(STEP_W)) u_p2 (.sys_clk(sys_clk), .rst(rst), .restart(restart),
		.ratio(p2_scale), .tick_in(bus_tick), .tick_out(p2_tick));

	// Registered outputs
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			bus_data_cycle <= 1'b0;
			servo_cycle <= 1'b0;
			interpolator_cycle <= 1'b0;
			second_interpolator_cycle <= 1'b0;
			first_external_fieldbus_port_cycle <= 1'b0;
			second_external_fieldbus_port_cycle <= 1'b0;
			using_slave_clock <= 1'b0;
			using_substitute_clock <= 1'b0;
		end else begin
			bus_data_cycle <= bus_tick;
			servo_cycle <= servo_tick;
			interpolator_cycle <= ipo_tick;
			second_interpolator_cycle <= second_interpolator_cycle_tick;
			first_external_fieldbus_port_cycle <= is_iso(p1_mode) & p1_tick;
			second_external_fieldbus_port_cycle <= is_iso(p2_mode) & p2_tick;
			using_slave_clock <= (state == ST_SLAVE);
			using_substitute_clock <= (state == ST_SUBST);
		end
	end
endmodule
`default_nettype wire

//--- rtl/fcc_consts.vh
// Constants for the fieldbus cycle clock derivation block
`ifndef FCC_CONSTS_VH
`define FCC_CONSTS_VH
`define FCC_CLK_NS 10
`define FCC_GRID_US 125
`define FCC_GRID_CYC ((`FCC_GRID_US * 1000) / `FCC_CLK_NS)
`define FCC_BUS_MIN_STEPS 4
`define FCC_EXT_MIN_STEPS 8
`define FCC_SERVO_MAX 8
`define FCC_IPO_MAX 6
`define FCC_SECOND_INTERPOLATOR_CYCLE_MIN 2
`define FCC_SECOND_INTERPOLATOR_CYCLE_MAX 64
`define FCC_IPO_MIN_STEPS 4
`define FCC_MODE_OFF 2'h0
`define FCC_MODE_FREE 2'h1
`define FCC_MODE_ISO_MASTER 2'h2
`define FCC_MODE_ISO_SLAVE 2'h3
`define FCC_ERR_BUS 0
`define FCC_ERR_EXT 1
`define FCC_ERR_SERVO 2
`define FCC_ERR_IPO 3
`define FCC_ERR_SECOND_INTERPOLATOR_CYCLE 4
`define FCC_ERR_IRT 5
`define FCC_ERR_TWO_SLAVES 6
`define FCC_ERR_SCALE 7
`define FCC_ERR_MASTER_CYC 8
`define FCC_ERR_W 9
`define FCC_ADDR_DEFAULT 7'h02
`endif

//--- rtl/fcc_divider.v
// Counting divider that emits one pulse every N input pulses
`include "fcc_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module fcc_divider #(
	parameter W = 8
) (
	// Clock and reset
	input wire sys_clk,
	input wire rst,
	// Control
	input wire restart,
	input wire [W-1:0] ratio,
	input wire tick_in,
	// Result
	output reg tick_out
);
	reg [W-1:0] count;
	// Output fires in the same cycle as the first input tick of each group,
	// so every level of the chain lines up with the bus tick
	always @* begin
		tick_out = tick_in && !restart && (count == {W{1'b0}});
	end
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			count <= {W{1'b0}};
		end else if (restart) begin
			count <= {W{1'b0}};
		end else begin
			if (tick_in) begin
				if (count + {{(W-1){1'b0}}, 1'b1} >= ratio)
					count <= {W{1'b0}};
				else
					count <= count + {{(W-1){1'b0}}, 1'b1};
			end
		end
	end
endmodule
`default_nettype wire

//--- tb/fcc_props.sv
// Property checker for the cycle clock derivation block
`timescale 1ns/1ps
`default_nettype none
module fcc_props #(parameter STEP_W = 8) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Configuration
	input wire logic cfg_load,
	input wire logic [STEP_W-1:0] cfg_bus_steps,
	input wire logic [3:0] cfg_servo_ratio,
	input wire logic cfg_irt,
	input wire logic [1:0] cfg_port1_mode,
	input wire logic [1:0] cfg_port2_mode,
	input wire logic cfg_port1_net,
	input wire logic cfg_port2_net,
	// Cycles and status
	input wire logic bus_data_cycle,
	input wire logic servo_cycle,
	input wire logic interpolator_cycle,
	input wire logic second_interpolator_cycle,
	input wire logic cfg_valid,
	input wire logic [8:0] cfg_error,
	input wire logic using_slave_clock,
	input wire logic using_substitute_clock,
	input wire logic [6:0] bus_addr
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	a_servo_on_bus: assert property (servo_cycle |-> bus_data_cycle) else $error("servo off bus edge");
	a_ipo_on_servo: assert property (interpolator_cycle |-> servo_cycle) else $error("ipo off servo");
	a_second_interpolator_cycle_on_ipo: assert property (second_interpolator_cycle |-> interpolator_cycle) else $error("second_interpolator_cycle off ipo");
	a_one_source: assert property (!(using_slave_clock && using_substitute_clock)) else $error("two sources");
	a_bus_short: assert property (cfg_load && cfg_bus_steps < 8'h04
		|=> cfg_error[0] && !cfg_valid) else $error("short bus cycle taken");
	a_irt_ratio: assert property (cfg_load && cfg_irt && cfg_servo_ratio != 4'h1
		|=> cfg_error[5] && !cfg_valid) else $error("ratio with irt taken");
	a_two_slaves: assert property (cfg_load && cfg_port1_mode == 2'h3 && cfg_port2_mode == 2'h3
		|=> cfg_error[6] && !cfg_valid) else $error("two slaves taken");
	a_addr_kept: assert property (cfg_load && !cfg_port1_net && !cfg_port2_net
		|=> $stable(bus_addr)) else $error("address taken without net");
endmodule
`default_nettype wire

//--- tb/fcc_remote_master.sv
// Remote isochronous master feeding a slave cycle
`timescale 1ns/1ps
`default_nettype none
module fcc_remote_master #(parameter PERIOD = 32) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Bench control
	input wire logic run,
	input wire logic lock,
	// Towards the block
	output logic slave_cycle,
	output logic sync_ok
);
	logic [7:0] cnt;
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cnt <= 8'h00;
			slave_cycle <= 1'b0;
		end else begin
			slave_cycle <= run && cnt == 8'h00;
			cnt <= (!run || cnt == PERIOD - 1) ? 8'h00 : cnt + 8'h01;
		end
	end
	assign sync_ok = run && lock;
endmodule
`default_nettype wire

//--- tb/tb.sv
// Self-checking bench for the cycle clock derivation block
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic sys_clk = 1'b0, rst = 1'b1, cfg_load = 1'b0, cfg_irt = 1'b0, cfg_port1_net = 1'b0, run = 1'b0, lock = 1'b0;
	logic on = 1'b0;
	logic [1:0] cfg_port1_mode = 2'h0, cfg_port2_mode = 2'h0;
	logic [3:0] cfg_servo_ratio = 4'h2, cfg_ipo_ratio = 4'h3;
	logic [6:0] cfg_second_interpolator_cycle_ratio = 7'h02;
	logic [7:0] cfg_bus_steps = 8'h04, cfg_port1_steps = 8'h08, cfg_port2_steps = 8'h08;
	wire port1_slave_cycle, port1_sync_ok, bus_data_cycle, servo_cycle, interpolator_cycle, second_interpolator_cycle;
	wire first_external_fieldbus_port_cycle, second_external_fieldbus_port_cycle, cfg_valid;
	wire using_slave_clock, using_substitute_clock;
	wire [8:0] cfg_error;
	wire [6:0] bus_addr;
	int n_errors = 0, samples_checked = 0, nb, ns, ni, nt, ne, nf;
	fcc_cycle_clock #(.GRID_CYC(4)) dut (.*, .port2_slave_cycle(1'b0), .port2_sync_ok(1'b0), .cfg_port2_net(1'b0),
		.cfg_bus_addr(7'h05));
	fcc_remote_master #(.PERIOD(64)) u_far (.sys_clk(sys_clk), .rst(rst), .run(run), .lock(lock),
		.slave_cycle(port1_slave_cycle),
		.sync_ok(port1_sync_ok));
	always #5 sys_clk = ~sys_clk;
	always @(negedge sys_clk) begin
		if (on) begin
			nb += bus_data_cycle;
			ns += servo_cycle;
			ni += interpolator_cycle;
			nt += second_interpolator_cycle;
			ne += first_external_fieldbus_port_cycle;
			nf += second_external_fieldbus_port_cycle;
		end
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task load(input logic [1:0] a = 2'h0, input logic [7:0] b = 8'h08, input logic [1:0] c = 2'h0,
		input logic [7:0] d = 8'h08, input logic e = 1'b0, input logic [3:0] f = 4'h2, input logic [3:0] g = 4'h3,
		input logic [6:0] h = 7'h02, input logic k = 1'b0, input logic [7:0] q = 8'h04);
		@(posedge sys_clk);
		{cfg_port1_mode, cfg_port1_steps, cfg_port2_mode, cfg_port2_steps, cfg_port1_net, cfg_servo_ratio,
			cfg_ipo_ratio, cfg_second_interpolator_cycle_ratio, cfg_irt, cfg_bus_steps} <= {a, b, c, d, e, f, g, h, k, q};
		cfg_load <= 1'b1;
		@(posedge sys_clk);
		cfg_load <= 1'b0;
		repeat (2) @(posedge sys_clk);
		#1;
	endtask
	// Counts pulses over 24 cycles of a 16-clock bus cycle
	task count();
		{nb, ns, ni, nt, ne, nf} = '0;
		repeat (8) @(posedge sys_clk);
		on <= 1'b1;
		repeat (384) @(posedge sys_clk);
		on <= 1'b0;
		@(posedge sys_clk);
		#1;
	endtask
	task test_done();
		$display("checks %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		#1;
		chk({cfg_valid, cfg_error, bus_addr}, {1'b1, 9'h000, 7'h02});
		$display("reset test done");
		load(, , , , , 4'h8, , 7'h40);
		chk(cfg_valid, 1'b1);
		load(, , , , , , , , , 8'h03);
		chk({cfg_valid, cfg_error[0]}, 2'b01);
		load(2'h2, 8'h04);
		chk({cfg_valid, cfg_error[1]}, 2'b01);
		load(, , , , , 4'h9);
		chk({cfg_valid, cfg_error[2]}, 2'b01);
		load(, , , , , , 4'h7);
		chk({cfg_valid, cfg_error[3]}, 2'b01);
		load(, , , , , , , 7'h41);
		chk({cfg_valid, cfg_error[4]}, 2'b01);
		load(, , , , , , , , 1'b1);
		chk({cfg_valid, cfg_error[5]}, 2'b01);
		load(2'h3, , 2'h3);
		chk({cfg_valid, cfg_error[6]}, 2'b01);
		load(2'h2);
		chk({cfg_valid, cfg_error[7]}, 2'b01);
		load(2'h3, , 2'h2, 8'h0c);
		chk({cfg_valid, cfg_error[8]}, 2'b01);
		$display("error table done");
		load();
		load(, , , , , , , , , 8'h03);
		count();
		chk(nb, 24);
		chk(ns, 12);
		chk(ni, 4);
		chk(nt, 2);
		chk(ne, 0);
		load();
		chk(bus_addr, 7'h02);
		load(, , , , 1'b1);
		chk(bus_addr, 7'h05);
		$display("timing and address done");
		@(posedge sys_clk);
		run <= 1'b1;
		lock <= 1'b1;
		load(2'h3, 8'h10, 2'h2, 8'h08, 1'b1, , , , , 8'h08);
		repeat (100) @(posedge sys_clk);
		#1;
		chk({cfg_valid, using_slave_clock, using_substitute_clock}, 3'b110);
		count();
		chk(nb, 12);
		chk(nf, 12);
		@(posedge sys_clk);
		lock <= 1'b0;
		repeat (4) @(posedge sys_clk);
		#1;
		chk({using_slave_clock, using_substitute_clock}, 2'b01);
		@(posedge sys_clk);
		lock <= 1'b1;
		load(2'h2, 8'h08, 2'h1, 8'h03, 1'b1, , , , , 8'h08);
		chk({cfg_valid, using_slave_clock, using_substitute_clock}, 3'b100);
		count();
		chk(nb, 12);
		chk(ne, 12);
		chk(nf, 0);
		$display("clock source done");
		test_done();
	end
	initial begin
		#300000;
		n_errors++;
		test_done();
	end
endmodule
bind fcc_cycle_clock fcc_props #(.STEP_W(STEP_W)) u_props (.*);
`default_nettype wire
